// *** verilog/pfs_pkg.sv ***
// Purpose: Shared constants and carrier types for the port0 pin function select block.
// Assumes: One 10 MHz core clock; registers reached over AXI4-Lite with 32-bit data.
// Notes: Addresses are full byte addresses on the processor memory map.
package pfs_pkg;

    // Number of port0 pins steered by the function select register.
    localparam int unsigned PIN_COUNT = 5;

    // Register byte addresses.
    localparam logic [31:0] FSEL_ADDR = 32'hffff0d00;
    localparam logic [31:0] STATUS_ADDR = 32'hffff0d3c;

    // Field positions inside the function select register.
    localparam int unsigned PIN_SEL_POS [PIN_COUNT] = '{0, 4, 8, 12, 16};
    localparam int unsigned LINE5_EN_POS = 20;
    localparam int unsigned LINE6_EN_POS = 24;
    localparam int unsigned KEEP_ONE_POS = 28;

    // Field positions inside the status register.
    localparam int unsigned STAT_PIN_POS = 0;
    localparam int unsigned STAT_CLK_POS = 8;

    // Reset value and the set of bits that hold state; the rest read as zero.
    localparam logic [31:0] FSEL_RESET = 32'h00000000;
    localparam logic [31:0] FSEL_RW_MASK = 32'h11111111;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing: core clock period and the clock output frequency.
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned CLK_FREQ_KHZ = 1000000 / CLK_PERIOD_NS;
    localparam int unsigned CLK_OUT_FREQ_KHZ = 2560;

    // Pad side of the port: output level and active-low output enable per pin.
    typedef struct packed {
        logic [PIN_COUNT-1:0] out;
        logic [PIN_COUNT-1:0] oe_n;
    } pfs_pad_t;

    // Drive request from a source of pin data (port data logic or SPI).
    typedef struct packed {
        logic [PIN_COUNT-1:0] out;
        logic [PIN_COUNT-1:0] en;
    } pfs_drive_t;

endpackage

// *** verilog/pfs_clk_gen.sv ***
// Purpose: Fractional divider that makes the clock output from the core clock.
// Assumes: The core clock runs continuously; the output is a square wave on average.
// Notes: Edges land on core clock edges, so single periods jitter by one core cycle.
module pfs_clk_gen
    import pfs_pkg::*;
#(
    parameter int unsigned IN_KHZ = CLK_FREQ_KHZ,
    parameter int unsigned OUT_KHZ = CLK_OUT_FREQ_KHZ
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset_n,
    // Generated clock level and its one-cycle toggle marker.
    output logic clk_out_ff,
    output logic toggle_ff
);

    // Accumulator steps by twice the output rate; each wrap is one half period.
    localparam int unsigned ACC_W = $clog2(IN_KHZ + 1);
    localparam logic [ACC_W:0] STEP = (ACC_W + 1)'(2 * OUT_KHZ);
    localparam logic [ACC_W:0] MODULUS = (ACC_W + 1)'(IN_KHZ);

    logic [ACC_W-1:0] acc_ff;
    logic [ACC_W:0] sum;
    logic wrap;

    // Compare before subtracting so the accumulator never exceeds the modulus.
    assign sum = {1'b0, acc_ff} + STEP;
    assign wrap = (sum >= MODULUS);

    // Phase accumulator; it runs freely so the output is continuous.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            acc_ff <= '0;
        end else if (wrap) begin
            acc_ff <= ACC_W'(sum - MODULUS);
        end else begin
            acc_ff <= ACC_W'(sum);
        end
    end

    // Output level flips on each wrap.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            clk_out_ff <= 1'b0;
            toggle_ff <= 1'b0;
        end else begin
            clk_out_ff <= clk_out_ff ^ wrap;
            toggle_ff <= wrap;
        end
    end

endmodule

// *** verilog/pfs_port0_mux.sv ***
// Purpose: Port0 function select register and the pin multiplexer it steers.
// Assumes: Pad inputs are synchronous to clock; AXI4-Lite master keeps one write and one read in flight.
// Notes: Every output is registered, so pin routing follows a register write by one cycle.
module pfs_port0_mux
    import pfs_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic reset_n,
    // AXI4-Lite write address and data.
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Port0 pads.
    input wire logic [PIN_COUNT-1:0] pad_in,
    output pfs_pad_t pad_o,
    // Port data logic side.
    input wire pfs_drive_t gpio_drive,
    output logic [PIN_COUNT-1:0] gpio_in_ff,
    // SPI side; pin four has no SPI role and its bit is unused.
    input wire pfs_drive_t spi_drive,
    output logic [PIN_COUNT-1:0] spi_in_ff,
    // Internal high-voltage interface line enables.
    output logic line5_en_ff,
    output logic line6_en_ff
);

    // Address match used by both the write and the read path.
    function automatic logic addr_hit(input logic [31:0] addr, input logic [31:0] reg_addr);
        addr_hit = (addr[31:2] == reg_addr[31:2]);
    endfunction

    logic [31:0] fsel_ff;
    logic [PIN_COUNT-1:0] pin_level_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [31:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [PIN_COUNT-1:0] pad_out_ff;
    logic [PIN_COUNT-1:0] pad_oe_n_ff;
    logic clk_out_level;
    logic clk_out_toggle;
    logic aw_take;
    logic w_take;
    logic do_write;
    logic ar_take;
    logic nxt_aw_held;
    logic nxt_w_held;
    logic nxt_bvalid;
    logic nxt_rvalid;
    logic [31:0] nxt_rdata;
    logic [31:0] status_word;
    wire [PIN_COUNT-1:0] nxt_pad_out;
    wire [PIN_COUNT-1:0] nxt_pad_oe_n;
    wire [PIN_COUNT-1:0] nxt_spi_in;
    wire [PIN_COUNT-1:0] pin_sel;

    // Clock output source for pin four.
    pfs_clk_gen #(
        .IN_KHZ(CLK_FREQ_KHZ),
        .OUT_KHZ(CLK_OUT_FREQ_KHZ)
    ) pfs_clk_gen_inst (
        .clock(clock),
        .reset_n(reset_n),
        .clk_out_ff(clk_out_level),
        .toggle_ff(clk_out_toggle)
    );

    // Write channel handshakes; address and data are taken in either order.
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign do_write = aw_held_ff && w_held_ff;
    assign nxt_aw_held = (aw_held_ff || aw_take) && !do_write;
    assign nxt_w_held = (w_held_ff || w_take) && !do_write;
    assign nxt_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);

    // Hold each write channel until both halves are in.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 32'h00000000;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            if (aw_take) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
        end
    end

    // Ready drops while a half is held or a response waits, so at most one write is open.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= !nxt_aw_held && !nxt_bvalid;
            s_axi_wready <= !nxt_w_held && !nxt_bvalid;
            s_axi_bvalid <= nxt_bvalid;
            if (do_write) begin
                s_axi_bresp <= addr_hit(awaddr_ff, FSEL_ADDR) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Function register; only select, enable and keep-one bits hold state, reserved bits read as zero.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            fsel_ff <= FSEL_RESET;
        end else if (do_write && addr_hit(awaddr_ff, FSEL_ADDR)) begin
            for (int b = 0; b < 4; b++) begin
                if (wstrb_ff[b]) begin
                    fsel_ff[b*8 +: 8] <= wdata_ff[b*8 +: 8] & FSEL_RW_MASK[b*8 +: 8];
                end
            end
        end
    end

    // Read path: one register stage, the answer follows the address by one cycle.
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign nxt_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);

    // Status shows sampled pad levels and the clock output level.
    // It is a read-only mirror, so software can watch the pads without claiming them.
    always_comb begin
        status_word = 32'h00000000;
        status_word[STAT_PIN_POS +: PIN_COUNT] = pin_level_ff;
        status_word[STAT_CLK_POS] = clk_out_level;
    end

    // Read data mux; unmapped addresses answer zero with an error.
    always_comb begin
        nxt_rdata = 32'h00000000;
        if (addr_hit(s_axi_araddr, FSEL_ADDR)) begin
            nxt_rdata = fsel_ff;
        end else if (addr_hit(s_axi_araddr, STATUS_ADDR)) begin
            nxt_rdata = status_word;
        end
    end

    // Read channel registers.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !nxt_rvalid;
            s_axi_rvalid <= nxt_rvalid;
            if (ar_take) begin
                s_axi_rdata <= nxt_rdata;
                s_axi_rresp <= (addr_hit(s_axi_araddr, FSEL_ADDR) || addr_hit(s_axi_araddr, STATUS_ADDR))
                    ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Pins zero to three choose between port data logic and their SPI signal.
    for (genvar i = 0; i < PIN_COUNT - 1; i++) begin : g_spi_pin
        assign pin_sel[i] = fsel_ff[PIN_SEL_POS[i]];
        assign nxt_pad_out[i] = pin_sel[i] ? spi_drive.out[i] : gpio_drive.out[i];
        assign nxt_pad_oe_n[i] = pin_sel[i] ? !spi_drive.en[i] : !gpio_drive.en[i];
        // An unselected SPI input idles high so an unrouted slave select looks inactive.
        assign nxt_spi_in[i] = pin_sel[i] ? pad_in[i] : 1'b1;
    end

    // Pin four chooses between port data logic and the always-driven clock output.
    assign pin_sel[PIN_COUNT-1] = fsel_ff[PIN_SEL_POS[PIN_COUNT-1]];
    assign nxt_pad_out[PIN_COUNT-1] = pin_sel[PIN_COUNT-1] ? clk_out_level : gpio_drive.out[PIN_COUNT-1];
    assign nxt_pad_oe_n[PIN_COUNT-1] = pin_sel[PIN_COUNT-1] ? 1'b0 : !gpio_drive.en[PIN_COUNT-1];
    assign nxt_spi_in[PIN_COUNT-1] = 1'b1;

    // Pad and input registers; pads float after reset until software or port logic drives them.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pad_out_ff <= '0;
            pad_oe_n_ff <= '1;
            spi_in_ff <= '1;
            gpio_in_ff <= '0;
            pin_level_ff <= '0;
        end else begin
            pad_out_ff <= nxt_pad_out;
            pad_oe_n_ff <= nxt_pad_oe_n;
            spi_in_ff <= nxt_spi_in;
            // Port data logic always sees the pad, even in alternate mode, for read-back.
            gpio_in_ff <= pad_in;
            pin_level_ff <= pad_in;
        end
    end

    assign pad_o.out = pad_out_ff;
    assign pad_o.oe_n = pad_oe_n_ff;

    // Internal high-voltage lines follow their enable bits.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            line5_en_ff <= 1'b0;
            line6_en_ff <= 1'b0;
        end else begin
            line5_en_ff <= fsel_ff[LINE5_EN_POS];
            line6_en_ff <= fsel_ff[LINE6_EN_POS];
        end
    end

    // Checks on the block's own behaviour.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    a_reset_clears_fsel: assert property ($rose(reset_n) |-> fsel_ff == FSEL_RESET && s_axi_bvalid == 1'b0)
        else $error("function register not zero after reset");
    a_write_updates_fsel: assert property (do_write && addr_hit(awaddr_ff, FSEL_ADDR) && wstrb_ff == 4'hf
        |=> fsel_ff == ($past(wdata_ff) & FSEL_RW_MASK) && s_axi_bvalid && s_axi_bresp == RESP_OKAY)
        else $error("full write did not land in function register");
    a_read_back_fsel: assert property (ar_take && addr_hit(s_axi_araddr, FSEL_ADDR)
        |=> s_axi_rvalid && s_axi_rdata == $past(fsel_ff))
        else $error("read of function register returned wrong data");
    a_line6_follows: assert property (fsel_ff[LINE6_EN_POS] ##1 fsel_ff[LINE6_EN_POS] |-> line6_en_ff)
        else $error("line six enable does not follow bit 24");
    a_line5_follows: assert property ($fell(fsel_ff[LINE5_EN_POS]) |=> !line5_en_ff)
        else $error("line five enable does not drop with bit 20");
    a_pin4_gpio_path: assert property (!pin_sel[PIN_COUNT-1]
        |=> pad_o.out[PIN_COUNT-1] == $past(gpio_drive.out[PIN_COUNT-1])
            && pad_o.oe_n[PIN_COUNT-1] == !$past(gpio_drive.en[PIN_COUNT-1]))
        else $error("pin four not following port data logic");
    a_pin4_clock_drive: assert property (pin_sel[PIN_COUNT-1] ##1 pin_sel[PIN_COUNT-1]
        |-> !pad_o.oe_n[PIN_COUNT-1] && pad_o.out[PIN_COUNT-1] == $past(clk_out_level))
        else $error("pin four not driving the clock output");
    a_clock_runs: assert property (clk_out_toggle |-> ##[1:2] clk_out_toggle)
        else $error("clock output stalled");
    a_spi_pin_route: assert property (pin_sel[3:0] == 4'hf
        |=> pad_o.out[3:0] == $past(spi_drive.out[3:0]) && pad_o.oe_n[3:0] == ~$past(spi_drive.en[3:0])
            && spi_in_ff[3:0] == $past(pad_in[3:0]))
        else $error("SPI pins not routed");
    a_gpio_pin_route: assert property (pin_sel[3:0] == 4'h0
        |=> pad_o.out[3:0] == $past(gpio_drive.out[3:0]) && spi_in_ff[3:0] == 4'hf)
        else $error("ordinary I/O pins not routed");

    // Refused accesses answer with an error and must leave the function register untouched.
    a_bresp_unmapped: assert property (do_write && !addr_hit(awaddr_ff, FSEL_ADDR)
        |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR && fsel_ff == $past(fsel_ff))
        else $error("unmapped write was not refused");
    a_read_unmapped: assert property (ar_take && !addr_hit(s_axi_araddr, FSEL_ADDR)
        && !addr_hit(s_axi_araddr, STATUS_ADDR) |=> s_axi_rvalid && s_axi_rdata == 32'h00000000
        && s_axi_rresp == RESP_SLVERR)
        else $error("unmapped read was not refused");

    // Mirror checks, so each line enable is watched both rising and falling.
    // Port data logic keeps seeing the pads in every mode, which read-back relies on.
    a_line5_rises: assert property (fsel_ff[LINE5_EN_POS] ##1 fsel_ff[LINE5_EN_POS] |-> line5_en_ff)
        else $error("line five enable does not follow bit 20");
    a_line6_drops: assert property ($fell(fsel_ff[LINE6_EN_POS]) |=> !line6_en_ff)
        else $error("line six enable does not drop with bit 24");
    a_pad_sampled: assert property (1'b1 |=> gpio_in_ff == $past(pad_in))
        else $error("port data logic does not see the pads");

    c_write_commit: cover property (aw_take && w_take ##1 do_write ##1 s_axi_bvalid);
    c_pin4_clock_mode: cover property (pin_sel[PIN_COUNT-1] ##1 clk_out_toggle ##1 clk_out_toggle);
    c_status_read: cover property (ar_take && addr_hit(s_axi_araddr, STATUS_ADDR) ##1 s_axi_rvalid);
    c_split_write: cover property (aw_take && !w_take ##[1:4] w_take);

endmodule

// *** verif/pfs_pad_model.sv ***
// Purpose: Model of the port0 pads with their pull-ups and an outside driver.
// Assumes: The block wins when both the block and the outside drive a pad.
// Notes: A released pad rises through its pull-up rather than keeping its last level.
module pfs_pad_model
    import pfs_pkg::*;
(
    // Pad side of the block.
    input wire pfs_pad_t pad_o,
    // Outside driver on each pin.
    input wire logic [PIN_COUNT-1:0] ext_en,
    input wire logic [PIN_COUNT-1:0] ext_lvl,
    // Resolved pad levels.
    output logic [PIN_COUNT-1:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // Resolve each pad from the enables of both parties.
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (!pad_o.oe_n[i]) begin
                pad_in[i] = pad_o.out[i];
            end else if (ext_en[i]) begin
                pad_in[i] = ext_lvl[i];
            end else begin
                pad_in[i] = 1'b1;
            end
        end
    end
endmodule

// *** verif/tb_pfs_port0_mux.sv ***
// Purpose: Self-checking bench for the port0 function register and its pin multiplexer.
// Assumes: The bus master keeps bready and rready high; pads are resolved by the pad model.
// Notes: Pin checks run on the falling edge against last cycle's inputs and register shadow.
module tb_pfs_port0_mux
    import pfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, line5, line6, have_prev, sel, po4;
    logic [31:0] awaddr, wdata, araddr, rdata, v, exp_reg, pin_reg, prev_r;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [PIN_COUNT-1:0] pad_in, gpio_in, spi_in, ext_en, ext_lvl, pp, es;
    pfs_pad_t pad_o, ep, em;
    pfs_drive_t gdrv, sdrv, pg, ps;
    logic [1:0] bq[$];
    logic [65:0] rq[$];
    logic [65:0] re;
    int mismatches = 0;
    int checks_done = 0;
    int toggles = 0;

    pfs_port0_mux pfs_port0_mux_inst (
        .clock(clock), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pad_in(pad_in), .pad_o(pad_o), .gpio_drive(gdrv), .gpio_in_ff(gpio_in),
        .spi_drive(sdrv), .spi_in_ff(spi_in), .line5_en_ff(line5), .line6_en_ff(line6)
    );
    pfs_pad_model pfs_pad_model_inst (.pad_o(pad_o), .ext_en(ext_en), .ext_lvl(ext_lvl), .pad_in(pad_in));

    // Free-running core clock.
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Core comparison; a mismatch is reported at once.
    task automatic cmp_bus(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Pin comparison; masked bits have no defined level.
    task automatic cmp_pin(input logic [9:0] got, input logic [9:0] exp, input logic [9:0] m);
        cmp_bus({22'h0, got & m}, {22'h0, exp & m});
    endtask

    // Write one word; the shadow follows byte strobes and the stored-bit mask.
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        bit ad = 0;
        bit dd = 0;
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        bq.push_back(r);
        if (a == FSEL_ADDR) begin
            exp_reg = (exp_reg & ~m) | (d & m & FSEL_RW_MASK);
        end
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge clock);
            if (!ad && awready) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (!dd && wready) begin
                dd = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (!bvalid);
    endtask

    // Read one word; only bits under the mask are compared.
    task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [1:0] r);
        rq.push_back({r, m, (a == FSEL_ADDR ? exp_reg : 32'h0) & m});
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock); while (!rvalid);
    endtask

    // Bus results meet the oldest note of their channel at the handshake edge.
    always @(posedge clock) begin
        if (reset_n && bvalid && bready && bq.size() > 0) begin
            cmp_bus({30'h0, bresp}, {30'h0, bq.pop_front()});
        end
        if (reset_n && rvalid && rready && rq.size() > 0) begin
            re = rq.pop_front();
            cmp_bus({30'h0, rresp}, {30'h0, re[65:64]});
            cmp_bus(rdata & re[63:32], re[31:0]);
        end
    end

    // Pins follow last cycle's register and drives; the register moves when bvalid shows.
    always @(negedge clock) begin
        if (!reset_n) begin
            have_prev = 1'b0;
            pin_reg = 32'h0;
        end else begin
            if (bvalid) begin
                pin_reg = exp_reg;
            end
            if (have_prev) begin
                em = '1;
                for (int i = 0; i < PIN_COUNT; i++) begin
                    sel = prev_r[4 * i];
                    ep.oe_n[i] = sel ? (i == 4 ? 1'b0 : !ps.en[i]) : !pg.en[i];
                    ep.out[i] = sel ? ps.out[i] : pg.out[i];
                    em.out[i] = !ep.oe_n[i] && !(sel && i == 4);
                    es[i] = (i < 4 && sel) ? pp[i] : 1'b1;
                end
                cmp_pin(pad_o, ep, em);
                cmp_pin({5'h0, gpio_in}, {5'h0, pp}, 10'h3ff);
                cmp_pin({5'h0, spi_in}, {5'h0, es}, 10'h3ff);
                cmp_pin({8'h0, line6, line5}, {8'h0, prev_r[24], prev_r[20]}, 10'h3ff);
                if (pad_o.out[4] !== po4) begin
                    toggles++;
                end
            end
            prev_r = pin_reg;
            pg = gdrv;
            ps = sdrv;
            pp = pad_in;
            po4 = pad_o.out[4];
            have_prev = 1'b1;
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog sized well beyond the fewer than 1500 cycles the tests need.
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        results();
    end

    // Main sequence; the forked driver keeps random drives and outside levels moving.
    initial begin
        void'($urandom(32'he721ced9));
        {reset_n, awvalid, wvalid, arvalid, awaddr, wdata, wstrb, araddr} = '0;
        {gdrv, sdrv, ext_en, ext_lvl, exp_reg} = '0;
        bready = 1'b1;
        rready = 1'b1;
        fork
            forever begin
                @(posedge clock);
                gdrv <= pfs_drive_t'(10'($urandom()));
                sdrv <= pfs_drive_t'(10'($urandom()));
                ext_en <= 5'($urandom());
                ext_lvl <= 5'($urandom());
            end
        join_none
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        rd(FSEL_ADDR, 32'hffffffff, RESP_OKAY);
        for (int k = 0; k < 12; k++) begin
            v = (k < 7) ? 32'h1 << (4 * k) : $urandom() & 32'h01111111;
            wr(FSEL_ADDR, v | 32'h10000000, 4'hf, RESP_OKAY);
            repeat (8) @(posedge clock);
            rd(FSEL_ADDR, 32'hffffffff, RESP_OKAY);
        end
        wr(FSEL_ADDR, 32'h10010000, 4'hf, RESP_OKAY);
        repeat (10) @(posedge clock);
        toggles = 0;
        repeat (1000) @(posedge clock);
        cmp_bus(32'(toggles >= 511 && toggles <= 513), 32'h1);
        wr(FSEL_ADDR, 32'h11111111, 4'hf, RESP_OKAY);
        wr(FSEL_ADDR, 32'h10000000, 4'h1, RESP_OKAY);
        rd(FSEL_ADDR, 32'hffffffff, RESP_OKAY);
        wr(STATUS_ADDR, 32'h10000000, 4'hf, RESP_SLVERR);
        wr(FSEL_ADDR + 32'h10, 32'h10000000, 4'hf, RESP_SLVERR);
        rd(FSEL_ADDR + 32'h10, 32'hffffffff, RESP_SLVERR);
        rd(STATUS_ADDR, 32'h0, RESP_OKAY);
        rd(FSEL_ADDR, 32'hffffffff, RESP_OKAY);
        reset_n <= 1'b0;
        exp_reg = 32'h0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        rd(FSEL_ADDR, 32'hffffffff, RESP_OKAY);
        repeat (4) @(posedge clock);
        results();
    end
endmodule
